/* File: pkg/cmc_pkg.sv */
// constants, field layout and types shared by the contact monitor control logic
package cmc_pkg;
	// command word layout
	localparam int          CMD_W          = 16;
	localparam logic [15:0] CMD_RESET      = 16'h0000;
	localparam int          HOLD_BIT       = 15;
	localparam int          SCAN_HI        = 14;
	localparam int          SCAN_LO        = 12;
	localparam int          GLOBAL_WET_BIT = 11;
	localparam int          PAIR_WET_BIT   = 10;
	localparam int          UPPER_POL_BIT  = 9;
	localparam int          MIDDLE_POL_BIT = 8;
	localparam int          MASK_HI        = 7;
	// status word layout
	localparam int          STAT_CONTACT_LO = 8;
	localparam int          STAT_OT_BIT     = 7;
	localparam logic [6:0]  STAT_UNUSED     = 7'h00;
	// serial frame
	localparam logic [4:0]  FRAME_BITS      = 5'h10;
	// timing
	localparam int          CLK_PERIOD_NS   = 4;
	localparam int          MS_NS           = 1000000;
	localparam int          MS_CYCLES_DEF   = MS_NS / CLK_PERIOD_NS;
	localparam int          POLL_US         = 250;
	localparam int          POLL_CYCLES_DEF = (POLL_US * 1000) / CLK_PERIOD_NS;
	localparam logic [4:0]  WET_PULSE_MS    = 5'h14;
	localparam int          DEB_MS_DEF      = 10;
	localparam logic [6:0]  BASE_PERIOD_MS  = 7'h40;

	// scan period codes
	typedef enum logic [2:0] {
		CMC_SCAN_64    = 3'h0,
		CMC_SCAN_32    = 3'h1,
		CMC_SCAN_16    = 3'h2,
		CMC_SCAN_8     = 3'h3,
		CMC_SCAN_4     = 3'h4,
		CMC_SCAN_2     = 3'h5,
		CMC_CONT_FIXED = 3'h6,
		CMC_CONT       = 3'h7
	} cmc_scan_t;

	// operating modes; debounce is the temporary normal mode entered from scan or normal
	typedef enum logic [1:0] {
		CMC_SHUTDOWN = 2'h0,
		CMC_SCANNING = 2'h1,
		CMC_NORMAL   = 2'h2,
		CMC_DEBOUNCE = 2'h3
	} cmc_mode_t;

	// continuous monitoring codes
	function automatic logic is_continuous(input logic [2:0] code);
		return code[2] & code[1];
	endfunction : is_continuous

	// scan period in milliseconds, halving per code step
	function automatic logic [6:0] scan_period_ms(input logic [2:0] code);
		return BASE_PERIOD_MS >> code;
	endfunction : scan_period_ms
endpackage : cmc_pkg

/* File: core/cmc_sync.sv */
// two flip-flop synchroniser for a bundle of asynchronous pins
module cmc_sync #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// pins and their synchronised copies
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	// first stage feeds only the second stage
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					stage1[g]   <= RST_VAL[g];
					sync_out[g] <= RST_VAL[g];
				end else begin
					stage1[g]   <= async_in[g];
					sync_out[g] <= stage1[g];
				end
			end
		end
	endgenerate
endmodule : cmc_sync

/* File: core/cmc_spi_slave.sv */
// serial slave: status shift-out, command shift-in, frame length check
module cmc_spi_slave (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// synchronised link pins
	input  wire logic        cs_n_s,
	input  wire logic        sclk_s,
	input  wire logic        sdi_s,
	// status to send
	input  wire logic [15:0] status_word,
	// serial out pin
	output logic             sdo,
	output logic             sdo_oe_n,
	// frame events
	output logic             frame_start,
	output logic             cmd_valid,
	output logic [15:0]      cmd_word
);
	logic        cs_q;
	logic        sclk_q;
	logic [15:0] shift;
	logic [4:0]  bit_cnt;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        cs_rise;

	// edges of the link; clock edges ignored while deselected
	assign frame_start = cs_q & ~cs_n_s;
	assign cs_rise     = ~cs_q & cs_n_s;
	assign sclk_rise   = ~sclk_q & sclk_s & ~cs_n_s;
	assign sclk_fall   = sclk_q & ~sclk_s & ~cs_n_s;
	assign sdo_oe_n    = cs_q;

	// edge history
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cs_q   <= 1'b1;
			sclk_q <= 1'b0;
		end else begin
			cs_q   <= cs_n_s;
			sclk_q <= sclk_s;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			shift   <= 16'h0000;
			sdo     <= 1'b0;
			bit_cnt <= 5'h00;
		end else if (frame_start) begin
			shift   <= status_word;
			sdo     <= status_word[15];
			bit_cnt <= 5'h00;
		end else begin
			if (sclk_rise) begin
				sdo <= shift[15];
			end
			if (sclk_fall) begin
				shift <= {shift[14:0], sdi_s};
				// saturate so long frames never wrap back to sixteen
				if (bit_cnt != 5'h1f) begin
					bit_cnt <= bit_cnt + 5'h01;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cmd_valid <= 1'b0;
			cmd_word  <= 16'h0000;
		end else begin
			cmd_valid <= cs_rise && (bit_cnt == cmc_pkg::FRAME_BITS);
			if (cs_rise && (bit_cnt == cmc_pkg::FRAME_BITS)) begin
				cmd_word <= shift;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_FRAME_LEN: assert property (cs_rise && bit_cnt != cmc_pkg::FRAME_BITS |=> !cmd_valid)
		else $error("command committed from a short or long frame");
	AST_LOAD_MSB: assert property (frame_start |=> sdo == $past(status_word[15]))
		else $error("status msb not presented at frame start");
	COV_FULL_FRAME: cover property (cmd_valid);
endmodule : cmc_spi_slave

/* File: core/cmc_top.sv */
// contact monitor control: command and status words, modes, debounce, wetting, alerts
module cmc_top #(
	parameter int MS_CYCLES   = cmc_pkg::MS_CYCLES_DEF,
	parameter int POLL_CYCLES = cmc_pkg::POLL_CYCLES_DEF,
	parameter int DEB_MS      = cmc_pkg::DEB_MS_DEF
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// serial link pins
	input  wire logic       spi_cs_n,
	input  wire logic       spi_sclk,
	input  wire logic       spi_sdi,
	output logic            spi_sdo,
	output logic            spi_sdo_oe_n,
	// front end levels
	input  wire logic [7:0] contact_inputs,
	input  wire logic       overtemp_sense,
	input  wire logic       shutdown_input_n,
	// open-drain alerts
	output logic            irq_pin_out,
	output logic            irq_pin_oe_n,
	output logic            ot_pin_out,
	output logic            ot_pin_oe_n,
	// analog front end controls
	output logic [7:0]      sense_connect,
	output logic [7:0]      wetting_on,
	output logic [7:0]      battery_sense,
	output logic            adj_hyst_enable,
	// direct level-shifted outputs
	output logic            direct_out_a,
	output logic            direct_out_b,
	output logic            direct_oe_n,
	// mode indication
	output logic            scan_mode
);
	logic [12:0]              sync_q;
	logic                     cs_n_s;
	logic                     sclk_s;
	logic                     sdi_s;
	logic [7:0]               in_s;
	logic                     overtemp_warning;
	logic                     sd_n_s;
	logic [15:0]              configuration_word;
	logic [15:0]              contact_status_word;
	logic [7:0]               contact_closed_bits;
	logic                     frame_start;
	logic                     cmd_valid;
	logic [15:0]              cmd_word;
	logic                     wetting_hold_mode;
	logic [2:0]               scan_code;
	logic                     global_wet;
	logic                     pair_wetting_enable;
	logic                     upper_pair_polarity;
	logic                     middle_pair_polarity;
	logic [7:0]               irq_mask_bits;
	logic [7:0]               polarity;
	logic [7:0]               eligible;
	logic [7:0]               closed_now;
	logic [7:0]               diff;
	logic [7:0]               diff_q;
	cmc_pkg::cmc_mode_t       mode;
	cmc_pkg::cmc_mode_t       next_mode;
	logic [23:0]              ms_cnt;
	logic                     ms_tick;
	logic [6:0]               scan_ms;
	logic [6:0]               period;
	logic [23:0]              poll_cnt;
	logic                     poll_window;
	logic                     poll_start;
	logic                     sensing;
	logic [7:0]               deb_ms;
	logic                     deb_done;
	logic [4:0]               wet_ms;
	logic                     wet_gate;
	logic                     irq_flag;
	logic                     irq_set;
	logic                     ot_flag;
	logic                     ot_q;

	// every pin crosses two flops before use
	cmc_sync #(.WIDTH(13), .RST_VAL(13'h1000)) u_sync (
		.clk      (clk),
		.reset    (reset),
		.async_in ({spi_cs_n, spi_sclk, spi_sdi, contact_inputs, overtemp_sense,
			shutdown_input_n}),
		.sync_out (sync_q)
	);
	assign {cs_n_s, sclk_s, sdi_s, in_s, overtemp_warning, sd_n_s} = sync_q;

	cmc_spi_slave u_spi (
		.clk         (clk),
		.reset       (reset),
		.cs_n_s      (cs_n_s),
		.sclk_s      (sclk_s),
		.sdi_s       (sdi_s),
		.status_word (contact_status_word),
		.sdo         (spi_sdo),
		.sdo_oe_n    (spi_sdo_oe_n),
		.frame_start (frame_start),
		.cmd_valid   (cmd_valid),
		.cmd_word    (cmd_word)
	);

	// command word cleared at reset and in shutdown
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			configuration_word <= cmc_pkg::CMD_RESET;
		end else if (!sd_n_s) begin
			configuration_word <= cmc_pkg::CMD_RESET;
		end else if (cmd_valid) begin
			configuration_word <= cmd_word;
		end
	end

	// command fields
	assign wetting_hold_mode    = configuration_word[cmc_pkg::HOLD_BIT];
	assign scan_code            = configuration_word[cmc_pkg::SCAN_HI:cmc_pkg::SCAN_LO];
	assign global_wet           = configuration_word[cmc_pkg::GLOBAL_WET_BIT];
	assign pair_wetting_enable  = configuration_word[cmc_pkg::PAIR_WET_BIT];
	assign upper_pair_polarity  = configuration_word[cmc_pkg::UPPER_POL_BIT];
	assign middle_pair_polarity = configuration_word[cmc_pkg::MIDDLE_POL_BIT];
	assign irq_mask_bits        = configuration_word[cmc_pkg::MASK_HI:0];

	// battery sensing per upper pairs, lower four ground
	assign polarity = {upper_pair_polarity, upper_pair_polarity,
		middle_pair_polarity, middle_pair_polarity, 4'h0};
	assign eligible   = {6'h3f, pair_wetting_enable, pair_wetting_enable};
	assign closed_now = ~(in_s ^ polarity);
	assign diff       = (closed_now ^ contact_closed_bits) & eligible;

	// live overtemperature level in bit 7
	assign contact_status_word = {contact_closed_bits, overtemp_warning, cmc_pkg::STAT_UNUSED};

	// millisecond time base shared by scan, debounce and wetting timers
	assign ms_tick = (ms_cnt == 24'(MS_CYCLES - 1));
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ms_cnt <= 24'h00_0000;
		end else begin
			ms_cnt <= ms_tick ? 24'h00_0000 : ms_cnt + 24'h00_0001;
		end
	end

	assign period      = cmc_pkg::scan_period_ms(scan_code);
	assign poll_start  = ms_tick && (scan_ms >= period - 7'h01);
	assign poll_window = (poll_cnt != 24'h00_0000);

	// scan period counter; restarts from zero after shutdown
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			scan_ms <= 7'h00;
		end else if (!sd_n_s) begin
			scan_ms <= 7'h00;
		end else if (ms_tick) begin
			scan_ms <= poll_start ? 7'h00 : scan_ms + 7'h01;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			poll_cnt <= 24'h00_0000;
		end else if (!sd_n_s || mode != cmc_pkg::CMC_SCANNING) begin
			poll_cnt <= 24'h00_0000;
		end else if (poll_start) begin
			poll_cnt <= 24'(POLL_CYCLES);
		end else if (poll_window) begin
			poll_cnt <= poll_cnt - 24'h00_0001;
		end
	end

	// inputs are only judged while their sense path is connected
	assign sensing = (mode == cmc_pkg::CMC_NORMAL) || (mode == cmc_pkg::CMC_DEBOUNCE) ||
		((mode == cmc_pkg::CMC_SCANNING) && poll_window);

	always_comb begin
		next_mode = mode;
		case (mode)
			cmc_pkg::CMC_SHUTDOWN: begin
				next_mode = cmc_pkg::is_continuous(scan_code) ? cmc_pkg::CMC_NORMAL :
					cmc_pkg::CMC_SCANNING;
			end
			cmc_pkg::CMC_SCANNING: begin
				if (cmc_pkg::is_continuous(scan_code)) begin
					next_mode = cmc_pkg::CMC_NORMAL;
				end else if (sensing && diff != 8'h00) begin
					next_mode = cmc_pkg::CMC_DEBOUNCE;
				end
			end
			cmc_pkg::CMC_NORMAL: begin
				if (!cmc_pkg::is_continuous(scan_code)) begin
					next_mode = cmc_pkg::CMC_SCANNING;
				end else if (diff != 8'h00) begin
					next_mode = cmc_pkg::CMC_DEBOUNCE;
				end
			end
			cmc_pkg::CMC_DEBOUNCE: begin
				if (diff == 8'h00 || deb_done) begin
					next_mode = cmc_pkg::is_continuous(scan_code) ? cmc_pkg::CMC_NORMAL :
						cmc_pkg::CMC_SCANNING;
				end
			end
			default: begin
				next_mode = cmc_pkg::CMC_SHUTDOWN;
			end
		endcase
		if (!sd_n_s) begin
			next_mode = cmc_pkg::CMC_SHUTDOWN;
		end
	end

	// reset lands in scan with code zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode <= cmc_pkg::CMC_SCANNING;
		end else begin
			mode <= next_mode;
		end
	end

	// debounce timer restarts whenever the pending set changes
	assign deb_done = (mode == cmc_pkg::CMC_DEBOUNCE) && (diff != 8'h00) &&
		(diff == diff_q) && ms_tick && (deb_ms >= 8'(DEB_MS - 1));
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			deb_ms <= 8'h00;
			diff_q <= 8'h00;
		end else begin
			diff_q <= diff;
			if (mode != cmc_pkg::CMC_DEBOUNCE || diff != diff_q || deb_done) begin
				deb_ms <= 8'h00;
			end else if (ms_tick && deb_ms != 8'hff) begin
				deb_ms <= deb_ms + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			contact_closed_bits <= 8'h00;
		end else if (!sd_n_s) begin
			contact_closed_bits <= 8'h00;
		end else if (deb_done) begin
			contact_closed_bits <= contact_closed_bits ^ diff;
		end
	end

	// one shared pulse timer, restarted by each valid change
	assign wet_gate = wetting_hold_mode || (wet_ms != 5'h00);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wet_ms <= 5'h00;
		end else if (!sd_n_s) begin
			wet_ms <= 5'h00;
		end else if (deb_done) begin
			wet_ms <= cmc_pkg::WET_PULSE_MS;
		end else if (ms_tick && wet_ms != 5'h00) begin
			wet_ms <= wet_ms - 5'h01;
		end
	end

	// pair needs both enables; overtemperature kills all wetting
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wetting_on <= 8'h00;
		end else if (!global_wet || overtemp_warning || !wet_gate || !sensing) begin
			wetting_on <= 8'h00;
		end else begin
			wetting_on <= contact_closed_bits & eligible;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sense_connect   <= 8'h00;
			battery_sense   <= 8'h00;
			adj_hyst_enable <= 1'b1;
			scan_mode       <= 1'b0;
		end else begin
			sense_connect   <= sensing ? eligible : 8'h00;
			battery_sense   <= polarity;
			adj_hyst_enable <= sd_n_s && (scan_code != cmc_pkg::CMC_CONT_FIXED);
			scan_mode       <= (mode == cmc_pkg::CMC_SCANNING);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			direct_out_a <= 1'b0;
			direct_out_b <= 1'b0;
			direct_oe_n  <= 1'b1;
		end else begin
			direct_out_a <= in_s[0];
			direct_out_b <= in_s[1];
			direct_oe_n  <= !(sd_n_s && !pair_wetting_enable &&
				cmc_pkg::is_continuous(scan_code));
		end
	end

	assign irq_set = deb_done && ((diff & ~irq_mask_bits) != 8'h00);

	// select fall clears alerts; a new event in that cycle wins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_flag <= 1'b0;
			ot_flag  <= 1'b0;
			ot_q     <= 1'b0;
		end else begin
			ot_q     <= overtemp_warning;
			irq_flag <= irq_set || (irq_flag && !frame_start);
			ot_flag  <= (overtemp_warning && !ot_q) || (ot_flag && !frame_start);
		end
	end

	// open-drain pins only ever pull low
	assign irq_pin_out  = 1'b0;
	assign irq_pin_oe_n = !irq_flag;
	assign ot_pin_out   = 1'b0;
	assign ot_pin_oe_n  = !ot_flag;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_SHUTDOWN_CLEAR: assert property (!sd_n_s |=> configuration_word == 16'h0000)
		else $error("command word survived shutdown");
	AST_IRQ_SET: assert property (irq_set |=> !irq_pin_oe_n)
		else $error("unmasked change did not pull interrupt low");
	AST_IRQ_MASKED: assert property (deb_done && (diff & ~irq_mask_bits) == 8'h00 &&
		irq_pin_oe_n |=> irq_pin_oe_n)
		else $error("masked change raised interrupt");
	AST_ALERT_RELEASE: assert property (frame_start && !irq_set |=> irq_pin_oe_n)
		else $error("interrupt not released at select fall");
	AST_DIRECT_HIZ: assert property (pair_wetting_enable |=> direct_oe_n)
		else $error("direct outputs driven with pair enable set");
	AST_SCAN_SENSE_OFF: assert property (mode == cmc_pkg::CMC_SCANNING && !poll_window
		|=> sense_connect == 8'h00)
		else $error("sensing connected outside poll window");
	AST_GLOBAL_WET: assert property (!global_wet |=> wetting_on == 8'h00)
		else $error("wetting on with global enable clear");
	AST_PAIR_WET: assert property (!pair_wetting_enable |=> wetting_on[1:0] == 2'h0 &&
		sense_connect[1:0] == 2'h0)
		else $error("pair wetting or sensing on with pair enable clear");
	AST_DIRECT_STATUS: assert property (!pair_wetting_enable && sd_n_s
		|=> contact_closed_bits[1:0] == $past(contact_closed_bits[1:0]))
		else $error("direct input changed status");
	AST_REVERT: assert property (mode == cmc_pkg::CMC_DEBOUNCE && diff == 8'h00 && sd_n_s
		|=> mode != cmc_pkg::CMC_DEBOUNCE)
		else $error("debounce not left after revert");
	AST_HYST_FIXED: assert property (scan_code == cmc_pkg::CMC_CONT_FIXED
		|=> !adj_hyst_enable)
		else $error("adjustable hysteresis on with code 110");

	COV_SCAN_DEBOUNCE: cover property (mode == cmc_pkg::CMC_SCANNING ##1
		mode == cmc_pkg::CMC_DEBOUNCE);
	COV_IRQ: cover property (irq_set);
	COV_WET_PULSE: cover property (!wetting_hold_mode && wetting_on != 8'h00);
endmodule : cmc_top

/* File: testbench/cmc_host_model.sv */
// host side serial master model that runs frames on the link pins
module cmc_host_model (
	// link pins driven by the host
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_sdi,
	// link pin read by the host
	input  wire logic spi_sdo
);
	timeunit 1ns;
	timeprecision 100ps;
	// link idles with select high and clock low
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_sdi  = 1'b0;
	end
	// msb first frame
	// a count below sixteen gives a short frame on purpose
	task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
		rx = 16'h0000;
		spi_cs_n <= 1'b0;
		#125;
		for (int i = 15; i > 15 - n; i--) begin
			spi_sclk <= 1'b1;
			spi_sdi  <= tx[i];
			#62.5;
			// sdo moves on the rising edge, so take it just before the fall
			rx = {rx[14:0], spi_sdo};
			spi_sclk <= 1'b0;
			#62.5;
		end
		#62.5;
		spi_cs_n <= 1'b1;
		spi_sdi  <= ~spi_sdi; // released line never keeps the last bit
		#125;
	endtask : xfer
endmodule : cmc_host_model

/* File: testbench/tb_top.sv */
// self-checking bench for the contact monitor control block
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, reset = 1'b1, overtemp_sense = 1'b0, shutdown_input_n = 1'b1;
	logic [7:0] contact_inputs = 8'hff;
	logic spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe_n, irq_pin_out, irq_pin_oe_n;
	logic ot_pin_out, ot_pin_oe_n, adj_hyst_enable, direct_out_a, direct_out_b;
	logic direct_oe_n, scan_mode;
	logic [7:0] sense_connect, wetting_on, battery_sense;
	logic [15:0] rx;
	logic sdo_line;
	// a deselected sdo shows the inverse of its last bit, so a stray sample shows up
	assign sdo_line = spi_sdo_oe_n ? ~spi_sdo : spi_sdo;
	int n_fail = 0, n_checks = 0, cnt;
	// clock at 250 MHz
	always #2 clk = ~clk;
	// short time base keeps the run brief
	cmc_top #(.MS_CYCLES(50), .POLL_CYCLES(10), .DEB_MS(2)) i_dut (.clk, .reset,
		.spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo, .spi_sdo_oe_n, .contact_inputs,
		.overtemp_sense, .shutdown_input_n, .irq_pin_out, .irq_pin_oe_n, .ot_pin_out,
		.ot_pin_oe_n, .sense_connect, .wetting_on, .battery_sense, .adj_hyst_enable,
		.direct_out_a, .direct_out_b, .direct_oe_n, .scan_mode);
	cmc_host_model i_host (.spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo(sdo_line));
	// compare and count
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// full frame write, then let the select rise cross the synchroniser
	task automatic cfg(input logic [15:0] w);
		i_host.xfer(w, 16, rx);
		repeat (12) @(posedge clk);
	endtask : cfg
	// bounded wait for the interrupt pin
	task automatic wait_irq();
		for (cnt = 0; cnt < 1000 && irq_pin_oe_n !== 1'b0; cnt++) @(posedge clk);
		chk("irq", 16'(irq_pin_oe_n), 16'h0000);
		if (cnt == 1000) print_verdict();
	endtask : wait_irq
	// single closing point
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict
	// main sequence; only status bits 15..7 are compared
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		repeat (8) @(posedge clk);
		chk("scan", 16'(scan_mode), 16'h0001);
		chk("batt", 16'(battery_sense), 16'h0000);
		i_host.xfer(16'h0000, 16, rx);
		chk("stat", rx & 16'hff80, 16'h0000);
		cfg(16'h7000);
		chk("scan", 16'(scan_mode), 16'h0000);
		chk("sense", 16'(sense_connect), 16'h00fc);
		chk("dir", 16'({direct_oe_n, direct_out_a}), 16'h0001);
		chk("pins", 16'({direct_out_b, spi_sdo_oe_n, irq_pin_out, ot_pin_out}), 16'h000c);
		cfg(16'h6000);
		chk("hyst", 16'(adj_hyst_enable), 16'h0000);
		cfg(16'hf840);
		@(posedge clk) contact_inputs <= 8'h7f;
		wait_irq();
		// wetting follows the committed status one edge later
		@(posedge clk);
		chk("wet", 16'(wetting_on), 16'h0080);
		i_host.xfer(16'hf840, 16, rx);
		chk("stat", rx & 16'hff80, 16'h8000);
		chk("irq", 16'(irq_pin_oe_n), 16'h0001);
		@(posedge clk) contact_inputs <= 8'h3f;
		repeat (300) @(posedge clk);
		chk("irq", 16'(irq_pin_oe_n), 16'h0001);
		chk("wet", 16'(wetting_on), 16'h00c0);
		// a closure that reverts well inside the debounce time must leave status alone
		@(posedge clk) contact_inputs <= 8'h1f;
		repeat (20) @(posedge clk);
		contact_inputs <= 8'h3f;
		i_host.xfer(16'h0000, 8, rx);
		repeat (12) @(posedge clk);
		chk("scan", 16'(scan_mode), 16'h0000);
		i_host.xfer(16'hf840, 16, rx);
		chk("stat", rx & 16'hff80, 16'hc000);
		cfg(16'h7700);
		chk("dir", 16'(direct_oe_n), 16'h0001);
		chk("sense", 16'(sense_connect), 16'h00ff);
		chk("batt", 16'(battery_sense), 16'h00f0);
		cfg(16'h7200);
		chk("batt", 16'(battery_sense), 16'h00c0);
		@(posedge clk) overtemp_sense <= 1'b1;
		repeat (10) @(posedge clk);
		chk("ot", 16'(ot_pin_oe_n), 16'h0000);
		i_host.xfer(16'h7200, 16, rx);
		chk("stat", rx & 16'h0080, 16'h0080);
		chk("ot", 16'(ot_pin_oe_n), 16'h0001);
		@(posedge clk) overtemp_sense <= 1'b0;
		repeat (400) @(posedge clk);
		cfg(16'h5200);
		repeat (200) @(posedge clk);
		chk("scan", 16'({direct_oe_n, scan_mode}), 16'h0003);
		// five whole periods of 100 cycles hold five windows of 10
		cnt = 0;
		repeat (500) @(posedge clk) cnt += int'(sense_connect[7]);
		chk("poll", 16'(cnt), 16'h0032);
		@(posedge clk) shutdown_input_n <= 1'b0;
		repeat (10) @(posedge clk);
		chk("sd", 16'({scan_mode, sense_connect}), 16'h0000);
		@(posedge clk) shutdown_input_n <= 1'b1;
		repeat (10) @(posedge clk);
		chk("sd", 16'({scan_mode, battery_sense}), 16'h0100);
		print_verdict();
	end
endmodule : tb_top
